// ### src/aiq_pkg.sv
// Purpose: shared constants for the analog input acquisition controller
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: offsets are byte addresses; all fields sit in the low bits
package aiq_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_NCHAN = 8'h08;
   localparam logic [7:0] OFS_DIFFERENTIAL_INPUT_MODE = 8'h0C;
   localparam logic [7:0] OFS_PRE = 8'h10;
   localparam logic [7:0] OFS_POST = 8'h14;
   localparam logic [7:0] OFS_DIV = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_DATA = 8'h20;
   // ------------------------------------------------------------
   // control command bits (write-only pulses)
   // ------------------------------------------------------------
   localparam int CTRL_START = 0;
   localparam int CTRL_STOP = 1;
   localparam int CTRL_CONVERT = 2;
   localparam int CTRL_CLR_OVF = 3;
   // ------------------------------------------------------------
   // mode register bits
   // ------------------------------------------------------------
   localparam int MODE_HW = 0;
   localparam int MODE_BUF = 1;
   localparam int MODE_CONT = 2;
   localparam int MODE_REF = 3;
   localparam int MODE_EXT = 4;
   localparam int MODE_FALL = 5;
   localparam int MODE_TRIG = 6;
   localparam int MODE_W = 7;
   // ------------------------------------------------------------
   // field widths, status layout and reset values
   // ------------------------------------------------------------
   localparam int CNT_W = 24;
   localparam int NCH_FW = 4;
   localparam int ST_BUSY = 3;
   localparam int ST_OVF = 4;
   localparam int ST_EMPTY = 5;
   localparam int ST_FULL = 6;
   localparam int ST_LVL_LSB = 8;
   localparam logic [NCH_FW-1:0] NCHAN_RST = 4'h1;
   localparam logic [CNT_W-1:0] DIV_RST = 24'h0003E8;
   // ------------------------------------------------------------
   // acquisition states, gray coded along the usual path
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ARMED = 3'b001,
      ST_PRE = 3'b011,
      ST_WREF = 3'b010,
      ST_POST = 3'b110
   } aiq_state_t;
endpackage

// ### src/aiq_sample_fifo.sv
// Purpose: onboard sample FIFO that overwrites the oldest word when full
// Assumes: DEPTH is a power of two
// Notes: ovf pulses for one cycle on each lost word
module aiq_sample_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // write and read side
   input wire logic push,
   input wire logic [W-1:0] wdata,
   input wire logic pop,
   output logic [W-1:0] rdata,
   // state
   output logic empty,
   output logic full,
   output logic [$clog2(DEPTH):0] level,
   output logic ovf
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] lvl_r;
   logic ovf_r;
   wire do_pop = pop & ~empty;
   // a push into a full fifo with no pop displaces the oldest word
   wire lose = push & full & ~do_pop;

   assign empty = (lvl_r == '0);
   assign full = (lvl_r == FULL_LVL);
   assign level = lvl_r;
   assign rdata = mem[rd_r];
   assign ovf = ovf_r;

   // storage array, no reset needed on data
   always_ff @(posedge hclk) begin
      if (push) begin
         mem[wr_r] <= wdata;
      end
   end

   // pointers and level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_r <= '0;
         rd_r <= '0;
         lvl_r <= '0;
         ovf_r <= 1'b0;
      end else begin
         wr_r <= push ? wr_r + 1'b1 : wr_r;
         rd_r <= (do_pop | lose) ? rd_r + 1'b1 : rd_r;
         lvl_r <= lvl_r + (AW+1)'(push & ~lose) - (AW+1)'(do_pop);
         ovf_r <= lose;
      end
   end
endmodule

// ### src/aiq_pace_gen.sv
// Purpose: sample pacing pulse from an internal divider or an external pin
// Assumes: external pacing input is synchronous to hclk
// Notes: one-cycle pulse per pacing period or per selected edge
module aiq_pace_gen #(
   parameter int CW = 24
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // configuration
   input wire logic run,
   input wire logic use_ext,
   input wire logic ext_fall,
   input wire logic [CW-1:0] div,
   // pacing sources and result
   input wire logic ext_clk,
   output logic pulse
);
   logic [CW-1:0] cnt_r;
   logic ext_d_r;
   logic pulse_r;
   wire ext_edge = ext_fall ? (ext_d_r & ~ext_clk) : (~ext_d_r & ext_clk);
   // a divide of zero is treated as one, so the divider never stalls
   wire wrap = (cnt_r == '0);

   assign pulse = pulse_r;

   // divider and edge detector
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '0;
         ext_d_r <= 1'b0;
         pulse_r <= 1'b0;
      end else begin
         ext_d_r <= ext_clk;
         if (!run || use_ext || wrap) begin
            cnt_r <= (div == '0) ? '0 : div - 1'b1;
         end else begin
            cnt_r <= cnt_r - 1'b1;
         end
         pulse_r <= run & (use_ext ? ext_edge : wrap);
      end
   end
endmodule

// ### src/aiq_acq_ctrl.sv
// Purpose: acquisition control for a multichannel analog input converter
// Assumes: single clock; converter answers each conv_start with one conv_done
// Notes: registers over AHB-Lite with one wait state per transfer
//
// Overview of operation
// - On-demand mode: each software convert command issued while idle yields exactly one conversion.
// - Hardware-timed mode paces scans from internal divider or external pacing input.
// - Hardware-timed runs may wait for the begin trigger input.
// - Buffered mode stores samples in FIFO and hands them out by DMA.
// - Finite mode acquires a preset sample count then stops by itself.
// - Continuous mode acquires without limit until software stops it.
// - Sample into full FIFO overwrites oldest data and flags overflow.
// - Non-buffered mode lets software read single samples straight from FIFO.
// - Three trigger actions exist: start, reference and pause.
// - All triggers are digital inputs; no analog level trigger exists.
// - Differential channel uses two mux inputs: signal positive, return negative.
// - Single-ended channel routes signal positive and input ground negative.
// - Each accepted pacing pulse samples every configured channel exactly once; pulses during a scan or pause are dropped.
// - Sample counter loads count, decrements per pacing pulse, segment ends at zero.
// - Reference trigger before pretrigger samples complete is ignored.
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
module aiq_acq_ctrl #(
   parameter int NCH = 8,
   parameter int FIFO_DEPTH = 16,
   parameter int DATA_W = 16
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // converter handshake
   output logic conv_start,
   input wire logic conv_done,
   input wire logic [DATA_W-1:0] conv_data,
   // multiplexer routing to the programmable_gain_amplifier
   output logic [$clog2(2*NCH)-1:0] mux_pos_sel,
   output logic [$clog2(2*NCH)-1:0] mux_neg_sel,
   output logic mux_neg_ground,
   // digital timing inputs
   input wire logic sample_pacing_clock,
   input wire logic acquisition_begin_input,
   input wire logic reference_event_input,
   input wire logic pause_input,
   // dma hand-off to host buffer
   output logic dma_req,
   output logic [DATA_W-1:0] dma_data,
   input wire logic dma_ack
);
   localparam int MW = $clog2(2*NCH);
   localparam int CHW = $clog2(NCH);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic reg_is(input logic [7:0] a, input logic [7:0] ofs);
      reg_is = (a == ofs);
   endfunction

   // differential channels take a second input bank for the return
   function automatic logic [MW-1:0] neg_route(input logic [CHW-1:0] ch);
      neg_route = MW'(ch) + MW'(NCH);
   endfunction

   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   logic pend_r;
   logic wr_r;
   logic [7:0] addr_r;
   logic hready_r;
   logic [31:0] hrdata_r;
   logic hresp_r;
   wire acc_w = hsel & hready & htrans[1];
   wire wr_en = pend_r & wr_r;
   wire rd_en = pend_r & ~wr_r;

   // address phase capture; every transfer takes one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_r <= 1'b0;
         wr_r <= 1'b0;
         addr_r <= 8'h00;
         hready_r <= 1'b1;
         hresp_r <= 1'b0;
      end else begin
         pend_r <= acc_w;
         hready_r <= ~acc_w;
         hresp_r <= 1'b0;
         if (acc_w) begin
            wr_r <= hwrite;
            addr_r <= haddr[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   logic [aiq_pkg::MODE_W-1:0] mode_r;
   logic [aiq_pkg::NCH_FW-1:0] nch_r;
   logic [NCH-1:0] differential_input_mode_r;
   logic [aiq_pkg::CNT_W-1:0] pre_r;
   logic [aiq_pkg::CNT_W-1:0] post_r;
   logic [aiq_pkg::CNT_W-1:0] div_r;
   wire ctrl_wr = wr_en & reg_is(addr_r, aiq_pkg::OFS_CTRL);
   wire start_cmd = ctrl_wr & hwdata[aiq_pkg::CTRL_START];
   wire stop_cmd = ctrl_wr & hwdata[aiq_pkg::CTRL_STOP];
   wire conv_cmd = ctrl_wr & hwdata[aiq_pkg::CTRL_CONVERT];
   wire clr_cmd = ctrl_wr & hwdata[aiq_pkg::CTRL_CLR_OVF];
   wire hw_mode = mode_r[aiq_pkg::MODE_HW];
   wire buf_mode = mode_r[aiq_pkg::MODE_BUF];
   wire cont_mode = mode_r[aiq_pkg::MODE_CONT];
   wire ref_mode = mode_r[aiq_pkg::MODE_REF];

   // register writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_r <= '0;
         nch_r <= aiq_pkg::NCHAN_RST;
         differential_input_mode_r <= '0;
         pre_r <= '0;
         post_r <= '0;
         div_r <= aiq_pkg::DIV_RST;
      end else if (wr_en) begin
         if (reg_is(addr_r, aiq_pkg::OFS_MODE)) mode_r <= hwdata[aiq_pkg::MODE_W-1:0];
         if (reg_is(addr_r, aiq_pkg::OFS_NCHAN)) nch_r <= hwdata[aiq_pkg::NCH_FW-1:0];
         if (reg_is(addr_r, aiq_pkg::OFS_DIFFERENTIAL_INPUT_MODE)) differential_input_mode_r <= hwdata[NCH-1:0];
         if (reg_is(addr_r, aiq_pkg::OFS_PRE)) pre_r <= hwdata[aiq_pkg::CNT_W-1:0];
         if (reg_is(addr_r, aiq_pkg::OFS_POST)) post_r <= hwdata[aiq_pkg::CNT_W-1:0];
         if (reg_is(addr_r, aiq_pkg::OFS_DIV)) div_r <= hwdata[aiq_pkg::CNT_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // trigger edges and pacing
   // ------------------------------------------------------------
   aiq_pkg::aiq_state_t st_r;
   aiq_pkg::aiq_state_t st_nxt;
   logic [aiq_pkg::CNT_W-1:0] cnt_r;
   logic [aiq_pkg::CNT_W-1:0] cnt_nxt;
   logic beg_d_r;
   logic ref_d_r;
   logic pace_pulse;
   logic scan_busy_r;
   wire beg_edge = acquisition_begin_input & ~beg_d_r;
   wire ref_edge = reference_event_input & ~ref_d_r;
   wire running = (st_r == aiq_pkg::ST_PRE) | (st_r == aiq_pkg::ST_WREF) |
                  (st_r == aiq_pkg::ST_POST);
   wire cnt_zero = (cnt_r == '0);
   // a pulse landing while a scan is still converting is dropped, not queued
   wire cnt_gate = (st_r == aiq_pkg::ST_WREF) | ~cnt_zero |
                   ((st_r == aiq_pkg::ST_POST) & cont_mode);
   wire pace_ok = pace_pulse & running & hw_mode & ~pause_input & ~scan_busy_r & cnt_gate;
   wire cnt_dec = pace_ok & ~cnt_zero & ~((st_r == aiq_pkg::ST_POST) & cont_mode);

   aiq_pace_gen #(
      .CW(aiq_pkg::CNT_W)
   ) u_pace (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(running),
      .use_ext(mode_r[aiq_pkg::MODE_EXT]),
      .ext_fall(mode_r[aiq_pkg::MODE_FALL]),
      .div(div_r),
      .ext_clk(sample_pacing_clock),
      .pulse(pace_pulse)
   );

   // ------------------------------------------------------------
   // acquisition state machine
   // ------------------------------------------------------------
   wire go_now = (st_r == aiq_pkg::ST_IDLE) ? (start_cmd & ~mode_r[aiq_pkg::MODE_TRIG]) :
                 ((st_r == aiq_pkg::ST_ARMED) & beg_edge);

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_dec ? cnt_r - 1'b1 : cnt_r;
      case (st_r)
         aiq_pkg::ST_IDLE: begin
            // optionally wait for the begin trigger
            if (start_cmd && hw_mode && mode_r[aiq_pkg::MODE_TRIG]) st_nxt = aiq_pkg::ST_ARMED;
         end
         aiq_pkg::ST_ARMED: begin
         end
         aiq_pkg::ST_PRE: begin
            // reference edges are not looked at here
            if (cnt_zero) st_nxt = aiq_pkg::ST_WREF;
         end
         aiq_pkg::ST_WREF: begin
            if (ref_edge) begin
               st_nxt = aiq_pkg::ST_POST;
               cnt_nxt = post_r;
            end
         end
         aiq_pkg::ST_POST: begin
            if (!cont_mode && cnt_zero && !scan_busy_r) st_nxt = aiq_pkg::ST_IDLE;
         end
         default: st_nxt = aiq_pkg::ST_IDLE;
      endcase
      // load the segment count on start
      if (go_now && hw_mode) begin
         st_nxt = ref_mode ? aiq_pkg::ST_PRE : aiq_pkg::ST_POST;
         cnt_nxt = ref_mode ? pre_r : post_r;
      end
      // only an explicit stop ends a continuous run
      if (stop_cmd) st_nxt = aiq_pkg::ST_IDLE;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= aiq_pkg::ST_IDLE;
         cnt_r <= '0;
         beg_d_r <= 1'b0;
         ref_d_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         beg_d_r <= acquisition_begin_input;
         ref_d_r <= reference_event_input;
      end
   end

   // ------------------------------------------------------------
   // channel scanner and mux routing
   // ------------------------------------------------------------
   logic [CHW-1:0] ch_r;
   logic od_r;
   logic conv_start_r;
   logic [MW-1:0] mux_pos_r;
   logic [MW-1:0] mux_neg_r;
   logic mux_gnd_r;
   // one command, one conversion, only when nothing else runs
   wire od_go = conv_cmd & ~hw_mode & ~scan_busy_r & (st_r == aiq_pkg::ST_IDLE);
   wire launch = pace_ok | od_go;
   wire last_ch = od_r | (aiq_pkg::NCH_FW'(ch_r) + 1'b1 >= nch_r);
   wire step = scan_busy_r & conv_done & ~last_ch;
   wire [CHW-1:0] ch_nxt = launch ? '0 : ch_r + 1'b1;

   // walk every configured channel once per accepted pacing pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scan_busy_r <= 1'b0;
         ch_r <= '0;
         od_r <= 1'b0;
         conv_start_r <= 1'b0;
      end else begin
         conv_start_r <= launch | step;
         if (launch) begin
            scan_busy_r <= 1'b1;
            od_r <= od_go;
         end else if (scan_busy_r && conv_done && last_ch) begin
            scan_busy_r <= 1'b0;
         end
         if (launch || step) ch_r <= ch_nxt;
      end
   end

   // route the amplifier inputs with each conversion start
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mux_pos_r <= '0;
         mux_neg_r <= '0;
         mux_gnd_r <= 1'b1;
      end else if (launch || step) begin
         mux_pos_r <= MW'(ch_nxt);
         mux_neg_r <= differential_input_mode_r[ch_nxt] ? neg_route(ch_nxt) : '0;
         mux_gnd_r <= ~differential_input_mode_r[ch_nxt];
      end
   end

   // ------------------------------------------------------------
   // sample fifo, dma and overflow
   // ------------------------------------------------------------
   logic [DATA_W-1:0] head;
   logic f_empty;
   logic f_full;
   logic [LW-1:0] f_level;
   logic f_ovf;
   logic ovf_r;
   logic dma_req_r;
   logic [DATA_W-1:0] dma_data_r;
   wire data_rd = rd_en & reg_is(addr_r, aiq_pkg::OFS_DATA) & ~buf_mode;
   wire dma_pop = dma_req_r & dma_ack;
   wire fifo_pop = dma_pop | data_rd;

   // conversions land in the overwriting fifo
   aiq_sample_fifo #(
      .W(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .hclk(hclk),
      .hresetn(hresetn),
      .push(scan_busy_r & conv_done),
      .wdata(conv_data),
      .pop(fifo_pop),
      .rdata(head),
      .empty(f_empty),
      .full(f_full),
      .level(f_level),
      .ovf(f_ovf)
   );

   // one word per request, request drops after each ack
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dma_req_r <= 1'b0;
         dma_data_r <= '0;
      end else if (dma_pop) begin
         dma_req_r <= 1'b0;
      end else if (!dma_req_r && buf_mode && !f_empty && !data_rd) begin
         dma_req_r <= 1'b1;
         dma_data_r <= head;
      end
   end

   // sticky overflow; a new loss wins over a clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovf_r <= 1'b0;
      end else begin
         ovf_r <= f_ovf | (ovf_r & ~clr_cmd & ~start_cmd);
      end
   end

   // ------------------------------------------------------------
   // read mux; a data read pops one sample outside buffered mode
   // ------------------------------------------------------------
   wire [31:0] status_w = {16'h0000, 8'(f_level), 1'b0, f_full, f_empty, ovf_r,
                           scan_busy_r, st_r};
   wire [31:0] rd_w =
      reg_is(addr_r, aiq_pkg::OFS_MODE) ? 32'(mode_r) :
      reg_is(addr_r, aiq_pkg::OFS_NCHAN) ? 32'(nch_r) :
      reg_is(addr_r, aiq_pkg::OFS_DIFFERENTIAL_INPUT_MODE) ? 32'(differential_input_mode_r) :
      reg_is(addr_r, aiq_pkg::OFS_PRE) ? 32'(pre_r) :
      reg_is(addr_r, aiq_pkg::OFS_POST) ? 32'(post_r) :
      reg_is(addr_r, aiq_pkg::OFS_DIV) ? 32'(div_r) :
      reg_is(addr_r, aiq_pkg::OFS_STATUS) ? status_w :
      reg_is(addr_r, aiq_pkg::OFS_DATA) ? 32'(head) : 32'h00000000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h00000000;
      end else if (rd_en) begin
         hrdata_r <= rd_w;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = hready_r;
   assign hresp = hresp_r;
   assign conv_start = conv_start_r;
   assign mux_pos_sel = mux_pos_r;
   assign mux_neg_sel = mux_neg_r;
   assign mux_neg_ground = mux_gnd_r;
   assign dma_req = dma_req_r;
   assign dma_data = dma_data_r;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_od_one_conv: assert property (od_go |=> conv_start_r ##1 !conv_start_r)
      else $error("on-demand command did not give one conversion");
   a_od_scan_end: assert property (scan_busy_r && od_r && conv_done |=> !scan_busy_r)
      else $error("on-demand scan kept running");
   a_pace_scan: assert property (pace_ok |=> conv_start_r && ch_r == '0)
      else $error("pacing pulse did not start a scan at channel zero");
   a_trig_hold: assert property (st_r == aiq_pkg::ST_ARMED && !beg_edge && !stop_cmd
                                 |=> st_r == aiq_pkg::ST_ARMED)
      else $error("left armed state without begin trigger");
   a_finite_end: assert property (st_r == aiq_pkg::ST_POST && !cont_mode && cnt_zero &&
                                  !scan_busy_r && !start_cmd |=> st_r == aiq_pkg::ST_IDLE)
      else $error("finite run did not stop at zero");
   a_cont_runs: assert property (st_r == aiq_pkg::ST_POST && cont_mode && !stop_cmd
                                 |=> st_r == aiq_pkg::ST_POST)
      else $error("continuous run ended without stop");
   a_cnt_dec: assert property (cnt_dec && !go_now && st_r != aiq_pkg::ST_WREF
                               |=> cnt_r == $past(cnt_r) - 1'b1)
      else $error("sample counter did not decrement");
   a_ref_early: assert property (st_r == aiq_pkg::ST_PRE && !cnt_zero && !start_cmd
                                 |=> st_r != aiq_pkg::ST_POST)
      else $error("early reference trigger accepted");
   a_ovf_sticky: assert property (f_ovf ##1 !clr_cmd && !start_cmd |=> ovf_r)
      else $error("overflow flag lost");
   a_mux_differential_input_mode: assert property (conv_start_r && differential_input_mode_r[ch_r] && $stable(differential_input_mode_r)
                                |-> mux_neg_r == neg_route(ch_r) && !mux_gnd_r)
      else $error("differential routing wrong");
   a_dma_drop: assert property (dma_pop |=> !dma_req_r)
      else $error("dma request held after ack");
endmodule

// ### verif/aiq_host_model.sv
// Purpose: far side model, converter and host dma buffer
// Assumes: conv_done four cycles after each conv_start
// Notes: ack is slow on purpose, three cycles after request
module aiq_host_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // converter side
   input wire logic conv_start,
   output logic conv_done,
   output logic [15:0] conv_data,
   // host buffer side
   input wire logic dma_req,
   input wire logic [15:0] dma_data,
   output logic dma_ack,
   output int words,
   output logic [15:0] last
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] val_r;
   logic [1:0] cdly_r;
   logic [1:0] adly_r;
   // data off the strobe is inverted so a late sample is caught
   assign conv_data = conv_done ? val_r : ~val_r;
   // one result per start, every word drained into host
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         val_r <= 16'hA000;
         cdly_r <= 2'h0;
         adly_r <= 2'h0;
         conv_done <= 1'h0;
         dma_ack <= 1'h0;
         words <= 0;
         last <= 16'h0;
      end else begin
         conv_done <= (cdly_r == 2'h1);
         cdly_r <= conv_start ? 2'h3 : cdly_r - 2'(cdly_r != 2'h0);
         if (conv_done) val_r <= val_r + 16'h1;
         adly_r <= (dma_req && !dma_ack && adly_r == 2'h0) ? 2'h2 : adly_r - 2'(adly_r != 2'h0);
         dma_ack <= (adly_r == 2'h1);
         if (dma_ack) words <= words + 1;
         if (dma_ack) last <= dma_data;
      end
   end
endmodule

// ### verif/testbench.sv
// Purpose: self-checking bench for the acquisition controller
// Assumes: one wait state per bus transfer, fifo depth 16
// Notes: timing inputs idle low; the trigger scenario pulses them one by one
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic hsel = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, q;
   logic hreadyout, hresp, conv_start, conv_done, dma_req, dma_ack, mux_neg_ground;
   logic [15:0] conv_data, dma_data, last;
   logic [3:0] mux_pos_sel, mux_neg_sel;
   logic [3:0] pins = 4'h0;
   int words, failures = 0, samples_checked = 0;
   always #2 hclk = ~hclk;
   aiq_acq_ctrl aiq_acq_ctrl_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .conv_start,
      .conv_done, .conv_data, .mux_pos_sel, .mux_neg_sel, .mux_neg_ground,
      .sample_pacing_clock(pins[0]), .acquisition_begin_input(pins[1]),
      .reference_event_input(pins[2]), .pause_input(pins[3]), .dma_req, .dma_data, .dma_ack);
   aiq_host_model aiq_host_model_inst (.hclk, .hresetn, .conv_start, .conv_done,
      .conv_data, .dma_req, .dma_data, .dma_ack, .words, .last);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one single word transfer, address phase held until hready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk(nm, e, q);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   // state field of the status word only
   task automatic stchk(input logic [2:0] e);
      bus(1'h0, aiq_pkg::OFS_STATUS, 32'h0);
      chk("state", {29'h0, e}, {29'h0, q[2:0]});
   endtask
   // one pulse on a timing input, long enough for a whole scan
   task automatic kick(input int k);
      @(posedge hclk);
      pins[k] <= 1'h1;
      repeat (20) @(posedge hclk);
      pins[k] <= 1'h0;
      repeat (20) @(posedge hclk);
   endtask
   task automatic t_reset;
      rdchk("mode", aiq_pkg::OFS_MODE, 32'h0);
      rdchk("nchan", aiq_pkg::OFS_NCHAN, 32'h1);
      rdchk("div", aiq_pkg::OFS_DIV, 32'h3E8);
      rdchk("unmapped", 8'h40, 32'h0);
   endtask
   task automatic t_demand;
      bus(1'h1, aiq_pkg::OFS_DIFFERENTIAL_INPUT_MODE, 32'h1);
      bus(1'h1, aiq_pkg::OFS_CTRL, 32'h4);
      repeat (10) @(posedge hclk);
      chk("neg_sel", 32'h8, {28'h0, mux_neg_sel});
      chk("neg_gnd", 32'h0, {31'h0, mux_neg_ground});
      bus(1'h1, aiq_pkg::OFS_DIFFERENTIAL_INPUT_MODE, 32'h0);
      bus(1'h1, aiq_pkg::OFS_CTRL, 32'h4);
      repeat (10) @(posedge hclk);
      chk("neg_gnd", 32'h1, {31'h0, mux_neg_ground});
      rdchk("data0", aiq_pkg::OFS_DATA, 32'hA000);
      rdchk("data1", aiq_pkg::OFS_DATA, 32'hA001);
      rdchk("status", aiq_pkg::OFS_STATUS, 32'h20);
   endtask
   task automatic t_finite;
      int n;
      n = 0;
      bus(1'h1, aiq_pkg::OFS_NCHAN, 32'h2);
      bus(1'h1, aiq_pkg::OFS_DIV, 32'h40);
      bus(1'h1, aiq_pkg::OFS_POST, 32'h3);
      bus(1'h1, aiq_pkg::OFS_MODE, 32'h3);
      bus(1'h1, aiq_pkg::OFS_CTRL, 32'h1);
      // poll until the run stops by itself, bounded
      do begin
         bus(1'h0, aiq_pkg::OFS_STATUS, 32'h0);
         n++;
      end while (q[2:0] !== 3'h0 && n < 300);
      repeat (40) @(posedge hclk);
      chk("words", 32'h6, 32'(words));
      chk("last", 32'hA007, {16'h0, last});
      chk("pos_sel", 32'h1, {28'h0, mux_pos_sel});
      rdchk("status", aiq_pkg::OFS_STATUS, 32'h20);
   endtask
   task automatic t_ovf;
      bus(1'h1, aiq_pkg::OFS_NCHAN, 32'h1);
      bus(1'h1, aiq_pkg::OFS_MODE, 32'h5);
      bus(1'h1, aiq_pkg::OFS_CTRL, 32'h1);
      repeat (1400) @(posedge hclk);
      bus(1'h1, aiq_pkg::OFS_CTRL, 32'h2);
      repeat (20) @(posedge hclk);
      rdchk("ovf", aiq_pkg::OFS_STATUS, 32'h1050);
      bus(1'h1, aiq_pkg::OFS_CTRL, 32'h8);
      rdchk("cleared", aiq_pkg::OFS_STATUS, 32'h1040);
   endtask
   // external pacing, begin and reference triggers, pause; dma drains the full fifo
   task automatic t_trig;
      bus(1'h1, aiq_pkg::OFS_PRE, 32'h2);
      bus(1'h1, aiq_pkg::OFS_POST, 32'h1);
      bus(1'h1, aiq_pkg::OFS_MODE, 32'h5B);
      bus(1'h1, aiq_pkg::OFS_CTRL, 32'h1);
      kick(2);
      stchk(3'h1);
      kick(1);
      stchk(3'h3);
      kick(2);
      stchk(3'h3);
      pins[3] <= 1'h1;
      kick(0);
      pins[3] <= 1'h0;
      kick(0);
      kick(0);
      stchk(3'h2);
      kick(2);
      kick(0);
      stchk(3'h0);
      chk("words", 32'h19, 32'(words));
   endtask
   task automatic conclude;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'h1;
      t_reset;
      t_demand;
      t_finite;
      t_ovf;
      t_trig;
      conclude;
   end
   // watchdog, about five times the expected run
   initial begin
      #40000;
      failures++;
      conclude;
   end
endmodule
